// File: dram_access_pkg.sv
// Constants for the display RAM access controller
package dram_access_pkg;
  localparam int          NUM_COLS        = 132;
  localparam int          NUM_LINES       = 64;
  localparam int          NUM_PAGES       = 8;
  localparam logic [7:0]  LAST_COL        = 8'h83;
  localparam logic [7:0]  CONTRAST_RST    = 8'h80;
  localparam logic [5:0]  START_LINE_RST  = 6'h00;
  localparam logic [7:0]  COL_RST         = 8'h00;
  localparam logic [2:0]  PAGE_RST        = 3'h0;
  localparam logic [1:0]  PUMP_RST        = 2'h2;
  localparam logic [5:0]  MUX_RST         = 6'h3F;
  // Command encodings
  localparam logic [3:0]  CMD_COL_LO_HI   = 4'h0;
  localparam logic [3:0]  CMD_COL_HI_HI   = 4'h1;
  localparam logic [5:0]  CMD_PUMP_HI     = 6'h0C;
  localparam logic [1:0]  CMD_START_HI    = 2'h1;
  localparam logic [7:0]  CMD_CONTRAST    = 8'h81;
  localparam logic [6:0]  CMD_REMAP_HI    = 7'h50;
  localparam logic [6:0]  CMD_ENTIRE_HI   = 7'h52;
  localparam logic [6:0]  CMD_INVERT_HI   = 7'h53;
  localparam logic [7:0]  CMD_MUX         = 8'hA8;
  localparam logic [7:0]  CMD_DCDC        = 8'hAD;
  localparam logic [6:0]  CMD_DCDC_VAL_HI = 7'h45;
  localparam logic [6:0]  CMD_DISP_HI     = 7'h57;
  localparam logic [6:0]  CMD_SCAN_HI     = 7'h64;
  localparam logic [3:0]  CMD_PAGE_HI     = 4'hB;
  // Serial byte frame
  localparam int          SER_BITS        = 8;
  localparam logic [3:0]  SER_LAST        = 4'h7;
  localparam int          FIFO_DEPTH      = 16;
endpackage

// File: dram_fifo.sv
// Small valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ns
module dram_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem[rd_ptr_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: display_ram_access_control.sv
// Host access logic: command/data separation, address counters, display RAM
`timescale 1ns/1ns
module display_ram_access_control #(
  parameter int COLS  = dram_access_pkg::NUM_COLS,
  parameter int LINES = dram_access_pkg::NUM_LINES
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Interface mode: 0 parallel 8080, 1 parallel 6800, 2 serial, 3 two-wire byte stream
  input  wire logic [1:0] bus_mode_i,
  // Parallel host pins
  input  wire logic       cs_n_i,
  input  wire logic       data_command_select_i,
  input  wire logic       rd_n_e_i,
  input  wire logic       wr_n_rw_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  // Serial host pins
  input  wire logic       ser_clk_i,
  input  wire logic       ser_data_i,
  // Decoded two-wire byte stream from the bus front end (same clock)
  input  wire logic       tw_byte_valid_i,
  input  wire logic [7:0] tw_byte_i,
  input  wire logic       tw_frame_start_i,
  // Clock source
  input  wire logic       oscillator_source_select_i,
  input  wire logic       osc_tick_i,
  input  wire logic       external_display_clock_i,
  output logic            display_clk_o,
  output logic            osc_enable_o,
  // Panel scan read port
  input  wire logic [5:0] scan_row_i,
  input  wire logic [7:0] scan_seg_i,
  output logic            seg_pixel_o,
  output logic      [5:0] scan_line_o,
  // Configuration state
  output logic      [7:0] contrast_o,
  output logic            col_reverse_o,
  output logic            com_reverse_o,
  output logic      [5:0] start_line_o,
  output logic            pump_on_o,
  output logic      [1:0] pump_level_o,
  output logic      [5:0] mux_ratio_o,
  output logic            display_on_o,
  output logic            entire_on_o,
  output logic            invert_o,
  output logic            drivers_oe_o,
  output logic      [2:0] page_o,
  output logic      [7:0] column_o,
  output logic            host_ready_o
);
  typedef enum logic [1:0] {
    ARG_NONE     = 2'b00,
    ARG_CONTRAST = 2'b01,
    ARG_MUX      = 2'b10,
    ARG_DCDC     = 2'b11
  } arg_state_t;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] rd_sync;
    logic [2:0] wr_sync;
    logic [1:0] dc_sync;
    logic [2:0] sclk_sync;
    logic [1:0] sdat_sync;
    logic [2:0] eclk_sync;
    logic [7:0] din_meta;
    logic [7:0] din_sync;
    logic [1:0] osc_sync;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic       tw_ctrl;
    logic       tw_last_ctrl;
    logic       tw_dc;
    logic       tw_one;
    arg_state_t arg;
    logic [7:0] contrast;
    logic       col_rev;
    logic       com_rev;
    logic [5:0] start_line;
    logic       pump_on;
    logic [1:0] pump_level;
    logic [5:0] mux;
    logic       disp_on;
    logic       entire_on;
    logic       invert;
    logic [2:0] page;
    logic [7:0] column;
    logic [7:0] rd_data;
    logic       rd_oe;
    logic       disp_clk;
    logic       pixel;
    logic [5:0] scan_line;
    logic       ready;
  } state_t;

  state_t     st_ff;
  state_t     nxt_st;
  logic [8:0] fifo_in;
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [8:0] fifo_out;
  logic       rd_req;
  logic [7:0] ram_rdata;
  logic [7:0] scan_rdata;
  logic       ram_we;
  localparam int NUM_RAM_ROWS = (LINES / 8) * COLS;
  logic [7:0] ram [NUM_RAM_ROWS];

  // Display RAM: one byte per page and column
  always_ff @(posedge core_clk_i) begin
    if (ram_we) begin
      ram[{st_ff.page, 7'h00} + st_ff.page * 4 + st_ff.column] <= fifo_out[7:0];
    end
  end
  assign ram_rdata = ram[{st_ff.page, 7'h00} + st_ff.page * 4 + st_ff.column];

  logic [5:0] eff_line;
  logic [7:0] eff_col;
  always_comb begin
    // Window of lines from the start line, wrapping at 64
    eff_line = st_ff.com_rev ? (6'd63 - scan_row_i) + st_ff.start_line
                             : scan_row_i + st_ff.start_line;
    eff_col  = st_ff.col_rev ? dram_access_pkg::LAST_COL - scan_seg_i : scan_seg_i;
  end
  assign scan_rdata = ram[{eff_line[5:3], 7'h00} + eff_line[5:3] * 4 + eff_col];

  dram_fifo #(
    .WIDTH (9),
    .DEPTH (dram_access_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (fifo_in_valid),
    .in_data_i   (fifo_in),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out),
    .out_ready_i (1'b1)
  );

  logic wr_fall;
  logic rd_fall;
  logic e_fall;
  logic sclk_rise;
  logic cmd_take;
  logic [7:0] cb;
  always_comb begin
    nxt_st  = st_ff;
    fifo_in_valid = 1'b0;
    fifo_in = '0;
    rd_req  = 1'b0;
    ram_we  = 1'b0;
    cb      = fifo_out[7:0];
    cmd_take = fifo_out_valid && !fifo_out[8];
    nxt_st.cs_sync   = {st_ff.cs_sync[1:0], cs_n_i};
    nxt_st.rd_sync   = {st_ff.rd_sync[1:0], rd_n_e_i};
    nxt_st.wr_sync   = {st_ff.wr_sync[1:0], wr_n_rw_i};
    nxt_st.dc_sync   = {st_ff.dc_sync[0], data_command_select_i};
    nxt_st.sclk_sync = {st_ff.sclk_sync[1:0], ser_clk_i};
    nxt_st.sdat_sync = {st_ff.sdat_sync[0], ser_data_i};
    nxt_st.eclk_sync = {st_ff.eclk_sync[1:0], external_display_clock_i};
    nxt_st.din_meta  = data_i;
    nxt_st.din_sync  = st_ff.din_meta;
    nxt_st.osc_sync  = {st_ff.osc_sync[0], oscillator_source_select_i};
    wr_fall   = st_ff.wr_sync[2] && !st_ff.wr_sync[1] && !st_ff.cs_sync[1];
    rd_fall   = st_ff.rd_sync[2] && !st_ff.rd_sync[1] && !st_ff.cs_sync[1];
    e_fall    = st_ff.rd_sync[2] && !st_ff.rd_sync[1] && !st_ff.cs_sync[1];
    sclk_rise = !st_ff.sclk_sync[2] && st_ff.sclk_sync[1] && !st_ff.cs_sync[1];
    nxt_st.ready = fifo_in_ready;

    case (bus_mode_i)
      2'd0: begin
        if (wr_fall) begin
          fifo_in_valid = 1'b1;
          fifo_in = {st_ff.dc_sync[1], st_ff.din_sync};
        end
        rd_req = rd_fall;
      end
      2'd1: begin
        // Access completes at the end of the high enable pulse
        if (e_fall && !st_ff.wr_sync[1]) begin
          fifo_in_valid = 1'b1;
          fifo_in = {st_ff.dc_sync[1], st_ff.din_sync};
        end
        rd_req = e_fall && st_ff.wr_sync[1];
      end
      2'd2: begin
        if (st_ff.cs_sync[1]) begin
          nxt_st.bit_cnt = '0;
          nxt_st.shift   = '0;
        end else if (sclk_rise) begin
          nxt_st.shift   = {st_ff.shift[6:0], st_ff.sdat_sync[1]};
          nxt_st.bit_cnt = st_ff.bit_cnt + 3'd1;
          if (st_ff.bit_cnt == dram_access_pkg::SER_LAST[2:0]) begin
            fifo_in_valid = 1'b1;
            fifo_in = {st_ff.dc_sync[1], st_ff.shift[6:0], st_ff.sdat_sync[1]};
          end
        end
      end
      default: begin
        if (tw_frame_start_i) begin
          nxt_st.tw_ctrl = 1'b1;
          nxt_st.tw_last_ctrl = 1'b0;
        end else if (tw_byte_valid_i) begin
          if (st_ff.tw_ctrl) begin
            nxt_st.tw_dc   = tw_byte_i[6];
            nxt_st.tw_one  = tw_byte_i[7];
            nxt_st.tw_ctrl = 1'b0;
          end else begin
            fifo_in_valid = 1'b1;
            fifo_in = {st_ff.tw_dc, tw_byte_i};
            nxt_st.tw_ctrl = st_ff.tw_one;
          end
        end
      end
    endcase

    // Read: present RAM byte, then advance column
    if (rd_req && st_ff.dc_sync[1]) begin
      nxt_st.rd_data = ram_rdata;
      nxt_st.rd_oe   = 1'b1;
    end else if (st_ff.rd_sync[1]) begin
      nxt_st.rd_oe = 1'b0;
    end

    // Commands and data drain one per cycle: no busy needed
    if (fifo_out_valid && fifo_out[8]) begin
      ram_we = 1'b1;
    end
    if ((ram_we || (rd_req && st_ff.dc_sync[1])) &&
        st_ff.column < dram_access_pkg::LAST_COL) begin
      nxt_st.column = st_ff.column + 8'd1;
    end
    if (cmd_take) begin
      case (st_ff.arg)
        ARG_CONTRAST: begin
          nxt_st.contrast = cb;
          nxt_st.arg = ARG_NONE;
        end
        ARG_MUX: begin
          nxt_st.mux = cb[5:0];
          nxt_st.arg = ARG_NONE;
        end
        ARG_DCDC: begin
          if (cb[7:1] == dram_access_pkg::CMD_DCDC_VAL_HI) begin
            nxt_st.pump_on = cb[0];
          end
          nxt_st.arg = ARG_NONE;
        end
        default: begin
          if (cb[7:4] == dram_access_pkg::CMD_COL_LO_HI) begin
            nxt_st.column = {st_ff.column[7:4], cb[3:0]};
          end else if (cb[7:4] == dram_access_pkg::CMD_COL_HI_HI) begin
            nxt_st.column = {cb[3:0], st_ff.column[3:0]};
          end else if (cb[7:2] == dram_access_pkg::CMD_PUMP_HI) begin
            nxt_st.pump_level = cb[1:0];
          end else if (cb[7:6] == dram_access_pkg::CMD_START_HI) begin
            nxt_st.start_line = cb[5:0];
          end else if (cb == dram_access_pkg::CMD_CONTRAST) begin
            nxt_st.arg = ARG_CONTRAST;
          end else if (cb[7:1] == dram_access_pkg::CMD_REMAP_HI) begin
            nxt_st.col_rev = cb[0];
          end else if (cb[7:1] == dram_access_pkg::CMD_ENTIRE_HI) begin
            nxt_st.entire_on = cb[0];
          end else if (cb[7:1] == dram_access_pkg::CMD_INVERT_HI) begin
            nxt_st.invert = cb[0];
          end else if (cb == dram_access_pkg::CMD_MUX) begin
            nxt_st.arg = ARG_MUX;
          end else if (cb == dram_access_pkg::CMD_DCDC) begin
            nxt_st.arg = ARG_DCDC;
          end else if (cb[7:1] == dram_access_pkg::CMD_DISP_HI) begin
            nxt_st.disp_on = cb[0];
          end else if (cb[7:4] == dram_access_pkg::CMD_PAGE_HI) begin
            nxt_st.page = cb[2:0];
          end else if (cb[7:4] == 4'hC) begin
            nxt_st.com_rev = cb[3];
          end
        end
      endcase
    end

    // Display clock: internal tick or synchronised external clock
    nxt_st.disp_clk = st_ff.osc_sync[1] ? osc_tick_i
                      : (st_ff.eclk_sync[1] && !st_ff.eclk_sync[2]);
    nxt_st.pixel     = (st_ff.entire_on | scan_rdata[eff_line[2:0]]) ^
                       (st_ff.invert & ~st_ff.entire_on);
    nxt_st.scan_line = eff_line;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff            <= '0;
      st_ff.cs_sync    <= 3'h7;
      st_ff.rd_sync    <= 3'h7;
      st_ff.wr_sync    <= 3'h7;
      st_ff.tw_ctrl    <= 1'b1;
      st_ff.arg        <= ARG_NONE;
      st_ff.contrast   <= dram_access_pkg::CONTRAST_RST;
      st_ff.pump_on    <= 1'b1;
      st_ff.pump_level <= dram_access_pkg::PUMP_RST;
      st_ff.mux        <= dram_access_pkg::MUX_RST;
      st_ff.start_line <= dram_access_pkg::START_LINE_RST;
      st_ff.column     <= dram_access_pkg::COL_RST;
      st_ff.page       <= dram_access_pkg::PAGE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign data_o        = st_ff.rd_data;
  assign data_oe_o     = st_ff.rd_oe;
  assign display_clk_o = st_ff.disp_clk;
  assign osc_enable_o  = st_ff.osc_sync[1];
  assign seg_pixel_o   = st_ff.pixel;
  assign scan_line_o   = st_ff.scan_line;
  assign contrast_o    = st_ff.contrast;
  assign col_reverse_o = st_ff.col_rev;
  assign com_reverse_o = st_ff.com_rev;
  assign start_line_o  = st_ff.start_line;
  assign pump_on_o     = st_ff.pump_on;
  assign pump_level_o  = st_ff.pump_level;
  assign mux_ratio_o   = st_ff.mux;
  assign display_on_o  = st_ff.disp_on;
  assign entire_on_o   = st_ff.entire_on;
  assign invert_o      = st_ff.invert;
  assign drivers_oe_o  = st_ff.disp_on;
  assign page_o        = st_ff.page;
  assign column_o      = st_ff.column;
  assign host_ready_o  = st_ff.ready;

  property p_col_stop;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (st_ff.column == dram_access_pkg::LAST_COL && ram_we && !cmd_take) |=> (column_o == dram_access_pkg::LAST_COL);
  endproperty
  a_col_stop: assert property (p_col_stop) else $error("column moved past 131");

  property p_col_inc;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (ram_we && st_ff.column < 8'd131) |=> (column_o == $past(st_ff.column) + 8'd1);
  endproperty
  a_col_inc: assert property (p_col_inc) else $error("column did not step");

  property p_start;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (cmd_take && st_ff.arg == ARG_NONE && cb[7:6] == 2'b01) |=> (start_line_o == $past(cb[5:0]));
  endproperty
  a_start: assert property (p_start) else $error("start line not loaded");

  property p_remap;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (cmd_take && st_ff.arg == ARG_NONE && cb[7:1] == 7'h50) |=> (col_reverse_o == $past(cb[0]));
  endproperty
  a_remap: assert property (p_remap) else $error("reversal not set");

  property p_contrast;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (cmd_take && st_ff.arg == ARG_CONTRAST) |=> (contrast_o == $past(cb));
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast not loaded");

  property p_colhi;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (cmd_take && st_ff.arg == ARG_NONE && cb[7:4] == 4'h1) |=> (column_o[7:4] == $past(cb[3:0]));
  endproperty
  a_colhi: assert property (p_colhi) else $error("high nibble not loaded");

  property p_page_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ram_we |=> (page_o == $past(st_ff.page));
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page moved on data");

  property p_pump;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (cmd_take && st_ff.arg == ARG_DCDC && cb == 8'h8B) |=> pump_on_o;
  endproperty
  a_pump: assert property (p_pump) else $error("pump not enabled");

  c_write: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) ram_we);
  c_cmd: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) cmd_take);
  c_end: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) column_o == 8'h83);
endmodule

// File: host_model.sv
// Host processor model driving the parallel port pins
`timescale 1ns/1ns
module host_model (
  // Clock and mode
  input  wire logic       core_clk_i,
  input  wire logic [1:0] bus_mode_i,
  // Read return
  input  wire logic       data_oe_i,
  input  wire logic [7:0] rd_data_i,
  // Host pins
  output logic            cs_n_o,
  output logic            dc_o,
  output logic            rd_n_e_o,
  output logic            wr_n_rw_o,
  output logic      [7:0] data_o
);
  initial begin
    cs_n_o = 1'b1;
    dc_o = 1'b0;
    rd_n_e_o = 1'b1;
    wr_n_rw_o = 1'b1;
    data_o = 8'hA5;
  end
  task automatic gap();
    repeat (4) @(negedge core_clk_i);
  endtask
  // Chip select and data/command level for the serial port
  task automatic sel(input logic cs_n, input logic dc);
    cs_n_o = cs_n;
    dc_o = dc;
    gap();
  endtask
  // Deselect, then park strobes at the idle level of the new mode
  task automatic park(input logic [1:0] mode);
    cs_n_o = 1'b1;
    gap();
    rd_n_e_o = (mode != 2'h1);
    wr_n_rw_o = 1'b1;
    gap();
  endtask
  // One byte write; only documented codes are sent
  task automatic put(input logic dc, input logic [7:0] val);
    cs_n_o = 1'b0;
    dc_o = dc;
    data_o = val;
    if (bus_mode_i == 2'h1) begin
      wr_n_rw_o = 1'b0;
      gap();
      rd_n_e_o = 1'b1;
      gap();
      rd_n_e_o = 1'b0;
      gap();
      wr_n_rw_o = 1'b1;
    end else begin
      gap();
      wr_n_rw_o = 1'b0;
      gap();
      wr_n_rw_o = 1'b1;
    end
    gap();
    data_o = ~val;
  endtask
  // One 8080 data read; reports drive enable seen while strobe is low
  task automatic get(output logic oe, output logic [7:0] val);
    cs_n_o = 1'b0;
    dc_o = 1'b1;
    gap();
    rd_n_e_o = 1'b0;
    gap();
    oe = data_oe_i;
    val = rd_data_i;
    rd_n_e_o = 1'b1;
    gap();
  endtask
endmodule

// File: display_ram_access_control_bench.sv
// Self-checking bench for the display RAM access controller
`timescale 1ns/1ns
module display_ram_access_control_bench;
  logic        clk;
  logic        rst_n = 1'b0;
  logic [1:0]  bus_mode = 2'h0;
  logic        osc_sel = 1'b1;
  logic [15:0] cnt = 16'h0000;
  logic        cs_n, dc, rd_n_e, wr_n_rw, data_oe, disp_clk, osc_en, pix, col_rev, com_rev;
  logic        pump_on, disp_on, entire, inv, drv_oe, ready, oe;
  logic [7:0]  din, dout, contrast, column, rd;
  logic [5:0]  scan_line, start_line, mux;
  logic [1:0]  pump_lvl;
  logic [2:0]  page;
  logic [7:0]  lines [3] = '{8'h40, 8'h7F, 8'h5D};
  logic [7:0]  tw_seq [7] = '{8'h80, 8'h10, 8'h80, 8'h05, 8'h40, 8'h99, 8'h66};
  logic [5:0]  row = 6'h00;
  logic [7:0]  seg = 8'h00;
  logic        sclk = 1'b0;
  logic        sdat = 1'b0;
  logic        tw_valid = 1'b0;
  logic        tw_start = 1'b0;
  logic [7:0]  tw_byte = 8'h00;
  logic [7:0]  nclk;
  int          n_errors = 0;
  int          checks = 0;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk) cnt <= cnt + 16'h0001;

  host_model host (.core_clk_i(clk), .bus_mode_i(bus_mode), .data_oe_i(data_oe), .rd_data_i(dout),
    .cs_n_o(cs_n), .dc_o(dc), .rd_n_e_o(rd_n_e), .wr_n_rw_o(wr_n_rw), .data_o(din));

  display_ram_access_control uut (.core_clk_i(clk), .rst_n_i(rst_n), .bus_mode_i(bus_mode),
    .cs_n_i(cs_n), .data_command_select_i(dc), .rd_n_e_i(rd_n_e), .wr_n_rw_i(wr_n_rw),
    .data_i(din), .data_o(dout), .data_oe_o(data_oe), .ser_clk_i(sclk), .ser_data_i(sdat),
    .tw_byte_valid_i(tw_valid), .tw_byte_i(tw_byte), .tw_frame_start_i(tw_start),
    .oscillator_source_select_i(osc_sel), .osc_tick_i(cnt[1:0] == 2'h0),
    .external_display_clock_i(cnt[2]), .display_clk_o(disp_clk), .osc_enable_o(osc_en),
    .scan_row_i(row), .scan_seg_i(seg), .seg_pixel_o(pix), .scan_line_o(scan_line),
    .contrast_o(contrast), .col_reverse_o(col_rev), .com_reverse_o(com_rev),
    .start_line_o(start_line), .pump_on_o(pump_on), .pump_level_o(pump_lvl), .mux_ratio_o(mux),
    .display_on_o(disp_on), .entire_on_o(entire), .invert_o(inv), .drivers_oe_o(drv_oe),
    .page_o(page), .column_o(column), .host_ready_o(ready));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    host.put(1'b0, b);
  endtask
  task automatic dat(input logic [7:0] b);
    host.put(1'b1, b);
  endtask
  // Serial byte, most significant bit first, clock idles low
  task automatic ser_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdat = b[i];
      host.gap();
      sclk = 1'b1;
      host.gap();
      sclk = 1'b0;
    end
    host.gap();
  endtask
  // One decoded two-wire byte, one cycle valid
  task automatic tw_send(input logic [7:0] b);
    tw_byte = b;
    tw_valid = 1'b1;
    @(negedge clk);
    tw_valid = 1'b0;
    @(negedge clk);
  endtask
  // Display clock pulses seen in sixteen cycles
  task automatic count_clk(output logic [7:0] n);
    n = 8'h00;
    repeat (16) begin
      @(negedge clk);
      n = n + {7'h00, disp_clk};
    end
  endtask
  task automatic defaults();
    check("display_on", disp_on, 8'h00);
    check("drivers_oe", drv_oe, 8'h00);
    check("col_reverse", col_rev, 8'h00);
    check("com_reverse", com_rev, 8'h00);
    check("start_line", start_line, dram_access_pkg::START_LINE_RST);
    check("column", column, dram_access_pkg::COL_RST);
    check("contrast", contrast, dram_access_pkg::CONTRAST_RST);
    check("pump_on", pump_on, 8'h01);
    check("mux", mux, dram_access_pkg::MUX_RST);
    check("pump_level", pump_lvl, dram_access_pkg::PUMP_RST);
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(negedge clk);
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (8) @(negedge clk);
    defaults();
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    defaults();
    cmd(8'hB3);
    check("page", page, 8'h03);
    cmd(8'h18);
    cmd(8'h01);
    check("column", column, 8'h81);
    dat(8'h55);
    check("column", column, 8'h82);
    cmd(8'hC8);
    check("column", column, 8'h82);
    dat(8'hAA);
    check("column", column, dram_access_pkg::LAST_COL);
    dat(8'h0F);
    check("column", column, dram_access_pkg::LAST_COL);
    check("page", page, 8'h03);
    cmd(8'h10);
    cmd(8'h00);
    check("column", column, 8'h00);
    host.get(oe, rd);
    check("data_oe", oe, 8'h01);
    check("column", column, 8'h01);
    cmd(8'h18);
    cmd(8'h01);
    host.get(oe, rd);
    check("read_data", rd, 8'h55);
    check("column", column, 8'h82);
    foreach (lines[i]) begin
      cmd(lines[i]);
      check("start_line", start_line, lines[i][5:0]);
    end
    for (int i = 1; i >= 0; i--) begin
      cmd(8'hA0 | i[7:0]);
      check("col_reverse", col_rev, i[7:0]);
    end
    cmd(8'h81);
    cmd(8'hFF);
    check("contrast", contrast, 8'hFF);
    cmd(8'hAD);
    cmd(8'h8A);
    check("pump_on", pump_on, 8'h00);
    cmd(8'hAD);
    cmd(8'h8B);
    check("pump_on", pump_on, 8'h01);
    cmd(8'h31);
    check("pump_level", pump_lvl, 8'h01);
    cmd(8'hA8);
    cmd(8'h1F);
    check("mux", mux, 8'h1F);
    // Reversed scan, start 1D: row 2 shows line 1A, page 3 bit 2
    row = 6'h02;
    seg = 8'h81;
    @(negedge clk);
    check("scan_line", scan_line, 8'h1A);
    check("pixel", pix, 8'h01);
    seg = 8'h82;
    @(negedge clk);
    check("pixel", pix, 8'h00);
    cmd(8'hA5);
    check("entire_on", entire, 8'h01);
    check("pixel", pix, 8'h01);
    cmd(8'hA7);
    check("invert", inv, 8'h01);
    check("pixel", pix, 8'h01);
    cmd(8'hA4);
    check("pixel", pix, 8'h01);
    cmd(8'hA6);
    check("invert", inv, 8'h00);
    check("pixel", pix, 8'h00);
    count_clk(nclk);
    check("display_clk", nclk, 8'h04);
    check("osc_enable", osc_en, 8'h01);
    osc_sel = 1'b0;
    repeat (3) @(negedge clk);
    check("osc_enable", osc_en, 8'h00);
    @(negedge clk);
    count_clk(nclk);
    check("display_clk", nclk, 8'h02);
    host.park(2'h1);
    bus_mode = 2'h1;
    host.park(2'h1);
    cmd(8'hA1);
    check("col_reverse", col_rev, 8'h01);
    seg = 8'h02;
    @(negedge clk);
    check("pixel", pix, 8'h01);
    seg = 8'h01;
    @(negedge clk);
    check("pixel", pix, 8'h00);
    dat(8'h3C);
    check("column", column, 8'h83);
    cmd(8'hAF);
    check("display_on", disp_on, 8'h01);
    check("host_ready", ready, 8'h01);
    host.park(2'h2);
    bus_mode = 2'h2;
    host.sel(1'b0, 1'b0);
    ser_byte(8'h6A);
    host.sel(1'b1, 1'b0);
    check("start_line", start_line, 8'h2A);
    bus_mode = 2'h3;
    tw_start = 1'b1;
    @(negedge clk);
    tw_start = 1'b0;
    foreach (tw_seq[i]) begin
      tw_send(tw_seq[i]);
    end
    repeat (6) @(negedge clk);
    check("column", column, 8'h07);
    rst_n = 1'b0;
    @(negedge clk);
    defaults();
    give_verdict();
  end
endmodule
